// >>> image_chunk_appender.sv
// Image stream pass-through that appends line, count and checksum chunks
`timescale 1ns/10ps
`default_nettype none
module image_chunk_appender #(
    parameter int NUM_LINES = 8,
    parameter int LINE_BASE = 0
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic acquisition_trigger_event_in,
    input wire logic [NUM_LINES-1:0] lines_in,
    input wire logic [31:0] pix_data_in,
    input wire logic pix_valid_in,
    input wire logic pix_last_in,
    output logic pix_ready_out,
    output logic [31:0] out_data_out,
    output logic out_valid_out,
    output logic out_last_out,
    input wire logic out_ready_in
);
    // ======================================================================
    // Elaboration check: line one and two must exist and fit the word
    if (NUM_LINES < 2 || LINE_BASE < 0 || NUM_LINES + LINE_BASE > 32) begin : g_bad
        $error("line mapping does not fit the 32-bit snapshot");
    end

    // ======================================================================
    // State
    typedef struct packed {
        chunk_pkg::emit_state_t st;
        logic metadata_mode_on;
        logic en_line;
        logic en_count;
        logic en_crc;
        logic [1:0] count_clear_origin;
        logic trigger_count_slot;
        logic event_is_trigger;
        logic [31:0] count;
        logic [31:0] snap;
        logic [31:0] count_snap;
        logic fr_line;
        logic fr_count;
        logic fr_crc;
        logic [15:0] crc;
        logic [15:0] crc_last;
        logic input_line_one_prev;
        logic input_line_two_prev;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic pix_ready;
        logic [31:0] o_data;
        logic o_valid;
        logic o_last;
        logic o_is_crc;
    } core_t;

    core_t s_q;
    core_t s_d;
    logic [31:0] line_word;
    logic trig;
    logic clear_evt;
    logic sw_clear;

    // ======================================================================
    // Functions
    // Bytewise CRC, low byte first, each byte MSB first
    function automatic logic [15:0] crc_word(input logic [15:0] c_in, input logic [31:0] w);
        logic [15:0] c;
        logic fb;
        c = c_in;
        for (int b = 0; b < 4; b++) begin
            for (int k = 7; k >= 0; k--) begin
                fb = c[15] ^ w[8*b+k];
                c = {c[14:0], 1'b0};
                if (fb) begin
                    c = c ^ chunk_pkg::CRC_POLY;
                end
            end
        end
        return c;
    endfunction : crc_word

    // Next chunk to send after the current one; PASS means payload ends
    function automatic chunk_pkg::emit_state_t next_chunk(
        input chunk_pkg::emit_state_t cur, input logic l, input logic c, input logic k);
        chunk_pkg::emit_state_t r;
        r = chunk_pkg::ST_PASS;
        case (cur)
            chunk_pkg::ST_PASS: r = l ? chunk_pkg::ST_LINE : c ? chunk_pkg::ST_COUNT :
                k ? chunk_pkg::ST_CRC : chunk_pkg::ST_PASS;
            chunk_pkg::ST_LINE: r = c ? chunk_pkg::ST_COUNT : k ? chunk_pkg::ST_CRC :
                chunk_pkg::ST_PASS;
            chunk_pkg::ST_COUNT: r = k ? chunk_pkg::ST_CRC : chunk_pkg::ST_PASS;
            default: r = chunk_pkg::ST_PASS;
        endcase
        return r;
    endfunction : next_chunk

    // ======================================================================
    // Line snapshot word: unmapped bits are tied low
    for (genvar i = 0; i < 32; i++) begin : g_line
        if (i >= LINE_BASE && i < LINE_BASE + NUM_LINES) begin : g_on
            assign line_word[i] = lines_in[i-LINE_BASE];
        end else begin : g_off
            assign line_word[i] = 1'b0;
        end
    end

    assign trig = acquisition_trigger_event_in;
    // Software clear is a write of one to the command bit
    assign sw_clear = s_q.aw_got && s_q.w_got && !s_q.bvalid &&
        s_q.aw_addr == chunk_pkg::ADDR_CMD && s_q.w_lane0 &&
        s_q.w_data[chunk_pkg::CMD_CLEAR_BIT];
    // Clear only counts when the trigger slot and trigger event are chosen
    always_comb begin
        clear_evt = 1'b0;
        if (s_q.trigger_count_slot && s_q.event_is_trigger) begin
            case (s_q.count_clear_origin)
                chunk_pkg::ORIGIN_INPUT_LINE_ONE: clear_evt = lines_in[0] && !s_q.input_line_one_prev;
                chunk_pkg::ORIGIN_INPUT_LINE_TWO: clear_evt = lines_in[1] && !s_q.input_line_two_prev;
                chunk_pkg::ORIGIN_SW: clear_evt = sw_clear;
                default: clear_evt = 1'b0;
            endcase
        end
    end

    // ======================================================================
    // Next-state logic
    always_comb begin
        logic free;
        logic [7:0] ra;
        chunk_pkg::emit_state_t nx;
        free = 1'b0;
        ra = 8'h00;
        nx = chunk_pkg::ST_PASS;
        s_d = s_q;
        s_d.input_line_one_prev = lines_in[0];
        s_d.input_line_two_prev = lines_in[1];

        // Trigger counter: clear first, so a same-cycle trigger reads one
        if (clear_evt) begin
            s_d.count = chunk_pkg::COUNT_ZERO;
        end
        if (trig) begin
            s_d.count = s_d.count + 32'h0000_0001;
            s_d.count_snap = s_d.count;
            s_d.snap = line_word;
            s_d.fr_line = s_q.en_line;
            s_d.fr_count = s_q.en_count;
            s_d.fr_crc = s_q.en_crc;
        end

        // Output register drains when the sink takes it
        if (s_q.o_valid && out_ready_in) begin
            s_d.o_valid = 1'b0;
        end
        free = !s_q.o_valid || out_ready_in;
        nx = next_chunk(s_q.st, s_q.fr_line, s_q.fr_count, s_q.fr_crc);
        case (s_q.st)
            chunk_pkg::ST_PASS: begin
                // Ready is only high while the output register is empty
                if (s_q.pix_ready && pix_valid_in) begin
                    s_d.o_valid = 1'b1;
                    s_d.o_data = pix_data_in;
                    s_d.o_is_crc = 1'b0;
                    s_d.o_last = pix_last_in && nx == chunk_pkg::ST_PASS;
                    s_d.crc = crc_word(s_q.crc, pix_data_in);
                    if (pix_last_in) begin
                        s_d.st = nx;
                        if (nx == chunk_pkg::ST_PASS) begin
                            s_d.crc = chunk_pkg::CRC_INIT;
                        end
                    end
                end
            end
            chunk_pkg::ST_LINE, chunk_pkg::ST_COUNT: begin
                if (free) begin
                    s_d.o_valid = 1'b1;
                    s_d.o_data = s_q.st == chunk_pkg::ST_LINE ? s_q.snap : s_q.count_snap;
                    s_d.o_is_crc = 1'b0;
                    s_d.o_last = nx == chunk_pkg::ST_PASS;
                    s_d.crc = crc_word(s_q.crc, s_d.o_data);
                    s_d.st = nx;
                    if (nx == chunk_pkg::ST_PASS) begin
                        s_d.crc = chunk_pkg::CRC_INIT;
                    end
                end
            end
            chunk_pkg::ST_CRC: begin
                // Checksum word itself stays out of the sum
                if (free) begin
                    s_d.o_valid = 1'b1;
                    s_d.o_data = {16'h0000, s_q.crc};
                    s_d.o_is_crc = 1'b1;
                    s_d.o_last = 1'b1;
                    s_d.crc_last = s_q.crc;
                    s_d.crc = chunk_pkg::CRC_INIT;
                    s_d.st = chunk_pkg::ST_PASS;
                end
            end
            default: s_d.st = chunk_pkg::ST_PASS;
        endcase
        s_d.pix_ready = s_d.st == chunk_pkg::ST_PASS && !s_d.o_valid;

        // Write channel: address and data taken in either order
        if (s_q.awready && s_axi_awvalid_in) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr_in;
        end
        if (s_q.wready && s_axi_wvalid_in) begin
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata_in;
            s_d.w_lane0 = s_axi_wstrb_in[0]; // Strobe only stands with wvalid
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.bvalid = 1'b1;
            s_d.bresp = chunk_pkg::RESP_OKAY;
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            case (s_q.aw_addr)
                chunk_pkg::ADDR_CTRL: begin
                    if (s_q.w_lane0) begin
                        // Enables stick only while metadata mode stays on
                        s_d.metadata_mode_on = s_q.w_data[chunk_pkg::CTRL_MODE_BIT];
                        s_d.en_line = s_q.w_data[chunk_pkg::CTRL_MODE_BIT] &&
                            s_q.w_data[chunk_pkg::CTRL_EN_LINE_BIT];
                        s_d.en_count = s_q.w_data[chunk_pkg::CTRL_MODE_BIT] &&
                            s_q.w_data[chunk_pkg::CTRL_EN_COUNT_BIT];
                        s_d.en_crc = s_q.w_data[chunk_pkg::CTRL_MODE_BIT] &&
                            s_q.w_data[chunk_pkg::CTRL_EN_CRC_BIT];
                    end
                end
                chunk_pkg::ADDR_CLEAR_CFG: begin
                    if (s_q.w_lane0) begin
                        s_d.count_clear_origin = s_q.w_data[chunk_pkg::CFG_ORIGIN_LSB +: 2];
                        s_d.trigger_count_slot = s_q.w_data[chunk_pkg::CFG_SLOT_BIT];
                        s_d.event_is_trigger = s_q.w_data[chunk_pkg::CFG_EVENT_BIT];
                    end
                end
                chunk_pkg::ADDR_CMD: s_d.bresp = chunk_pkg::RESP_OKAY;
                default: s_d.bresp = chunk_pkg::RESP_SLVERR;
            endcase
        end
        if (s_q.bvalid && s_axi_bready_in) begin
            s_d.bvalid = 1'b0;
        end
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;

        // Read channel: one word per request, answered next cycle
        if (s_q.arready && s_axi_arvalid_in) begin
            ra = s_axi_araddr_in;
            s_d.rvalid = 1'b1;
            s_d.rresp = chunk_pkg::RESP_OKAY;
            case (ra)
                chunk_pkg::ADDR_CTRL: s_d.rdata = {28'h0000000, s_q.en_crc, s_q.en_count,
                    s_q.en_line, s_q.metadata_mode_on};
                chunk_pkg::ADDR_CLEAR_CFG: s_d.rdata = {28'h0000000, s_q.event_is_trigger,
                    s_q.trigger_count_slot, s_q.count_clear_origin};
                chunk_pkg::ADDR_CMD: s_d.rdata = 32'h0000_0000;
                chunk_pkg::ADDR_COUNT: s_d.rdata = s_q.count;
                chunk_pkg::ADDR_SNAP: s_d.rdata = s_q.snap;
                chunk_pkg::ADDR_CRC: s_d.rdata = {16'h0000, s_q.crc_last};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = chunk_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && s_axi_rready_in) begin
            s_d.rvalid = 1'b0;
        end
        s_d.arready = !s_d.rvalid;
    end

    // ======================================================================
    // State register; reset stands for a power cycle
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
            s_q.st <= chunk_pkg::ST_PASS;
            s_q.count_clear_origin <= chunk_pkg::ORIGIN_OFF;
            s_q.crc <= chunk_pkg::CRC_INIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready_out = s_q.awready;
    assign s_axi_wready_out = s_q.wready;
    assign s_axi_bresp_out = s_q.bresp;
    assign s_axi_bvalid_out = s_q.bvalid;
    assign s_axi_arready_out = s_q.arready;
    assign s_axi_rdata_out = s_q.rdata;
    assign s_axi_rresp_out = s_q.rresp;
    assign s_axi_rvalid_out = s_q.rvalid;
    assign pix_ready_out = s_q.pix_ready;
    assign out_data_out = s_q.o_data;
    assign out_valid_out = s_q.o_valid;
    assign out_last_out = s_q.o_last;

    // ======================================================================
    // Checks
    logic free_w;
    assign free_w = !s_q.o_valid || out_ready_in;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    AST_COUNT_INC: assert property (trig && !clear_evt |=>
        s_q.count == $past(s_q.count) + 32'h0000_0001) else $error("count did not step");
    AST_COUNT_CLEAR: assert property (clear_evt && !trig |=> s_q.count == 32'h0)
        else $error("clear did not zero count");
    AST_ORIGIN_OFF: assert property (
        s_q.count_clear_origin == chunk_pkg::ORIGIN_OFF |-> !clear_evt)
        else $error("clear while origin off");
    AST_SW_ONLY: assert property (
        clear_evt && s_q.count_clear_origin == chunk_pkg::ORIGIN_SW |-> sw_clear)
        else $error("software clear without command");
    AST_SLOT_GATE: assert property (!s_q.trigger_count_slot |-> !clear_evt)
        else $error("clear with other slot chosen");
    AST_SNAP: assert property (trig |=> s_q.snap == $past(line_word))
        else $error("snapshot not captured");
    AST_SNAP_ZERO: assert property (
        NUM_LINES + LINE_BASE < 32 |-> s_q.snap[31] == 1'b0) else $error("unmapped bit set");
    AST_MODE_GATE: assert property (
        !s_q.metadata_mode_on |-> !s_q.en_line && !s_q.en_count && !s_q.en_crc)
        else $error("chunk enabled without mode");
    AST_CRC_WORD: assert property (s_q.st == chunk_pkg::ST_CRC && free_w |=>
        s_q.o_is_crc && s_q.o_data[15:0] == $past(s_q.crc)) else $error("bad checksum word");
    AST_CRC_LAST: assert property (s_q.o_valid && s_q.o_is_crc |-> s_q.o_last)
        else $error("checksum not last");
    AST_CHUNK_ADD: assert property (s_q.st == chunk_pkg::ST_PASS && s_q.fr_line &&
        s_q.pix_ready && pix_valid_in && pix_last_in |=> s_q.st == chunk_pkg::ST_LINE)
        else $error("line chunk skipped");
endmodule : image_chunk_appender
`default_nettype wire

// >>> chunk_pkg.sv
// Constants, register map and state codes for the image chunk appender
// ==========================================================================
`default_nettype none
package chunk_pkg;
    // ======================================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLEAR_CFG = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_SNAP = 8'h10;
    localparam logic [7:0] ADDR_CRC = 8'h14;
    // ======================================================================
    // Field positions
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_EN_LINE_BIT = 1;
    localparam int CTRL_EN_COUNT_BIT = 2;
    localparam int CTRL_EN_CRC_BIT = 3;
    localparam int CFG_ORIGIN_LSB = 0;
    localparam int CFG_SLOT_BIT = 2;
    localparam int CFG_EVENT_BIT = 3;
    localparam int CMD_CLEAR_BIT = 0;
    // ======================================================================
    // Clear origin codes
    localparam logic [1:0] ORIGIN_OFF = 2'h0;
    localparam logic [1:0] ORIGIN_INPUT_LINE_ONE = 2'h1;
    localparam logic [1:0] ORIGIN_INPUT_LINE_TWO = 2'h2;
    localparam logic [1:0] ORIGIN_SW = 2'h3;
    // ======================================================================
    // Checksum and bus answers
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ======================================================================
    // Emit sequencer states
    typedef enum logic [3:0] {
        ST_PASS = 4'b0001,
        ST_LINE = 4'b0010,
        ST_COUNT = 4'b0100,
        ST_CRC = 4'b1000
    } emit_state_t;
endpackage : chunk_pkg
`default_nettype wire

// >>> host_sink.sv
// Host-side sink that collects payload words and verifies the trailing checksum
`timescale 1ns/10ps
`default_nettype none
module host_sink (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic slow_in,
    input wire logic [31:0] data_in,
    input wire logic valid_in,
    input wire logic last_in,
    output logic ready_out,
    output logic good_out,
    output int frames_out
);
    logic [31:0] got[$];
    logic [15:0] crc_q;
    // ======================================================================
    // Serial checksum: bytes low first, each byte MSB first
    function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] w);
        logic fb;
        for (int i = 0; i < 32; i++) begin
            fb = c[15] ^ w[8 * (i / 8) + 7 - (i % 8)];
            c = {c[14:0], 1'b0} ^ (fb ? chunk_pkg::CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : crc_word
    // ======================================================================
    // Slow mode toggles ready so the appender must hold each word
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ready_out <= 1'b0;
            crc_q <= 16'h0000;
            good_out <= 1'b0;
            frames_out <= 0;
        end else begin
            ready_out <= slow_in ? ~ready_out : 1'b1;
            if (valid_in && ready_out) begin
                got.push_back(data_in);
                crc_q <= last_in ? 16'h0000 : crc_word(crc_q, data_in);
                if (last_in) begin
                    good_out <= (data_in === {16'h0000, crc_q});
                    frames_out <= frames_out + 1;
                end
            end
        end
    end
endmodule : host_sink
`default_nettype wire

// >>> test_image_chunk_appender.sv
// Self-checking bench for the image chunk appender
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_image_chunk_appender;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, lines = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pix_ready, out_valid, out_last, out_ready;
    logic [31:0] wdata = 32'h0, pix_data = 32'h0, rdata, out_data, exp_cnt = 32'h0;
    logic [1:0] bresp, rresp;
    logic trig = 1'b0, pix_valid = 1'b0, pix_last = 1'b0;
    int failures = 0, tests_run = 0;
    image_chunk_appender DUT (.clk_sys_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .acquisition_trigger_event_in(trig), .lines_in(lines),
        .pix_data_in(pix_data), .pix_valid_in(pix_valid), .pix_last_in(pix_last),
        .pix_ready_out(pix_ready), .out_data_out(out_data), .out_valid_out(out_valid),
        .out_last_out(out_last), .out_ready_in(out_ready));
    host_sink host (.clk_sys_in(clk), .sys_rst_in(rst), .slow_in(slow), .data_in(out_data),
        .valid_in(out_valid), .last_in(out_last), .ready_out(out_ready), .good_out(),
        .frames_out());
    // ======================================================================
    // Clock, 50 ns period
    always #25 clk = ~clk;
    // Verdict and end of run, shared by every hang
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    task automatic hang();
        failures++;
        $display("wait timed out at %0t", $time);
        close_out();
    endtask : hang
    // ======================================================================
    // Bus master: valids held until their own ready edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
        // Idle edge so a following call never re-raises bready in this step
        @(posedge clk);
        if (n == 40) hang();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        // Idle edge so a following call never re-raises rready in this step
        @(posedge clk);
        if (n == 40) hang();
    endtask : rd
    // ======================================================================
    // Stimulus helpers: trigger, line pulse, image words, frame wait
    task automatic fire();
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        exp_cnt++;
        @(posedge clk);
    endtask : fire
    task automatic pulse(input int k);
        lines[k] <= 1'b1;
        repeat (2) @(posedge clk);
        lines[k] <= 1'b0;
        @(posedge clk);
    endtask : pulse
    task automatic send_img(input int n);
        int k, t, f0;
        f0 = host.frames_out;
        host.got.delete();
        for (k = 0; k < n; k++) begin
            pix_data <= 32'h1000_0000 + 32'(k);
            pix_valid <= 1'b1;
            pix_last <= (k == n - 1);
            for (t = 0; t < 50 && !(pix_valid && pix_ready); t++) @(posedge clk);
            if (t == 50) hang();
            pix_valid <= 1'b0;
            @(posedge clk);
        end
        for (t = 0; t < 300 && host.frames_out == f0; t++) @(posedge clk);
        if (t == 300) hang();
    endtask : send_img
    task automatic chk_cnt();
        logic [31:0] d;
        logic [1:0] r;
        rd(chunk_pkg::ADDR_COUNT, d, r);
        `CHK(d, exp_cnt)
    endtask : chk_cnt
    // ======================================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd(chunk_pkg::ADDR_CLEAR_CFG, d, r);
        `CHK(d, 32'h0)
        rd(chunk_pkg::ADDR_COUNT, d, r);
        `CHK(d, 32'h0)
        rd(8'h1c, d, r);
        `CHK(r, chunk_pkg::RESP_SLVERR)
        wr(8'h1c, 32'h1, r);
        `CHK(r, chunk_pkg::RESP_SLVERR)
        wr(chunk_pkg::ADDR_CTRL, 32'he, r);
        `CHK(r, chunk_pkg::RESP_OKAY)
        rd(chunk_pkg::ADDR_CTRL, d, r);
        `CHK(d, 32'h0)
        wr(chunk_pkg::ADDR_CTRL, 32'hf, r);
        rd(chunk_pkg::ADDR_CTRL, d, r);
        `CHK(d, 32'hf)
        wr(chunk_pkg::ADDR_CTRL, 32'h0, r);
        rd(chunk_pkg::ADDR_CTRL, d, r);
        `CHK(d, 32'h0)
        $display("test regs done");
    endtask : t_regs
    task automatic t_image();
        logic [1:0] r;
        slow <= 1'b1;
        lines <= 8'ha5;
        wr(chunk_pkg::ADDR_CTRL, 32'hf, r);
        fire();
        lines <= 8'h00;
        send_img(3);
        `CHK(host.got.size(), 6)
        `CHK(host.got[2], 32'h1000_0002)
        `CHK(host.got[3], 32'h0000_00a5)
        `CHK(host.got[4], exp_cnt)
        `CHK(host.got[5][31:16], 16'h0000)
        `CHK(host.good_out, 1'b1)
        slow <= 1'b0;
        wr(chunk_pkg::ADDR_CTRL, 32'h9, r);
        fire();
        send_img(2);
        `CHK(host.got.size(), 3)
        `CHK(host.good_out, 1'b1)
        wr(chunk_pkg::ADDR_CTRL, 32'h0, r);
        fire();
        send_img(2);
        `CHK(host.got.size(), 2)
        `CHK(host.good_out, 1'b0)
        $display("test image done");
    endtask : t_image
    task automatic t_clear();
        logic [1:0] r;
        for (int s = 0; s < 4; s++) begin
            wr(chunk_pkg::ADDR_CLEAR_CFG, {28'h0, 2'b11, 2'(s)}, r);
            fire();
            pulse(0);
            if (s == 1) exp_cnt = 32'h0;
            chk_cnt();
            fire();
            pulse(1);
            if (s == 2) exp_cnt = 32'h0;
            chk_cnt();
            fire();
            wr(chunk_pkg::ADDR_CMD, 32'h1, r);
            if (s == 3) exp_cnt = 32'h0;
            chk_cnt();
        end
        wr(chunk_pkg::ADDR_CLEAR_CFG, {28'h0, 2'b10, chunk_pkg::ORIGIN_SW}, r);
        fire();
        wr(chunk_pkg::ADDR_CMD, 32'h1, r);
        chk_cnt();
        wr(chunk_pkg::ADDR_CLEAR_CFG, {28'h0, 2'b01, chunk_pkg::ORIGIN_INPUT_LINE_ONE}, r);
        fire();
        pulse(0);
        chk_cnt();
        $display("test clear done");
    endtask : t_clear
    task automatic t_power();
        logic [31:0] d;
        logic [1:0] r;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        exp_cnt = 32'h0;
        chk_cnt();
        rd(chunk_pkg::ADDR_CLEAR_CFG, d, r);
        `CHK(d, 32'h0)
        $display("test power done");
    endtask : t_power
    // ======================================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_image();
        t_clear();
        t_power();
        close_out();
    end
endmodule : test_image_chunk_appender
`default_nettype wire
